// ---- cbo_defs.vh ----
`ifndef CBO_DEFS_VH
`define CBO_DEFS_VH

// register indices; byte address is four times the index
`define CBO_IDX_SEL0 20'hFFFA5
`define CBO_IDX_SEL1 20'hFFFA6
`define CBO_IDX_PWR 20'hFFFA7
`define CBO_IDX_STAT 20'hFFFA8
`define CBO_IDX_SET0 20'hFFFA9
`define CBO_IDX_CLR0 20'hFFFAA
`define CBO_IDX_SET1 20'hFFFAB
`define CBO_IDX_CLR1 20'hFFFAC

`define CBO_ADDR_W 22
`define CBO_IDX_W 20

// select register layout
`define CBO_EN_BIT 7
`define CBO_SRC_BIT 3
`define CBO_DIV_MSB 2
`define CBO_DIV_LSB 0
`define CBO_SEL_RESET 8'h00
`define CBO_SEL_WMASK 8'h8F

// power control register layout
`define CBO_PWR_LPGATE_BIT 0
`define CBO_PWR_RESET 8'h00

// status register layout
`define CBO_STAT_OUT0_BIT 0
`define CBO_STAT_ACT0_BIT 1
`define CBO_STAT_OUT1_BIT 2
`define CBO_STAT_ACT1_BIT 3
`define CBO_STAT_SUB_BIT 4

// prescaler widths
`define CBO_MAIN_CNT_W 13
`define CBO_SUB_CNT_W 7

`endif

// ---- cbo_chan.v ----
`timescale 1ns/100ps
// one output channel: free phase, enable taken only at a rising phase edge
module cbo_chan (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire tick, // half-period event of selected clock
  input wire en, // software enable bit
  output reg out_q, // channel output level
  output reg active_q // enable as seen by output stage
);

  reg ph_q;
  wire ph_d;

  assign ph_d = ~ph_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 1'b0;
      active_q <= 1'b0;
      out_q <= 1'b0;
    end else if (tick) begin
      ph_q <= ph_d;
      // enable sampled only where a high phase would begin
      if (ph_d) begin
        active_q <= en; // [RQ6]
        out_q <= en; // [RQ7]
      end else begin
        // a started high phase always completes
        out_q <= 1'b0; // [RQ7]
      end
    end else if (!active_q) begin
      out_q <= 1'b0; // [RQ17]
    end
  end

endmodule // cbo_chan

// ---- cbo_clock_buzzer_output.v ----
// Function
// [RQ1] Two independent channels, each with own select register and own output pin.
// [RQ2] Select bit 7 enables channel output; zero, the reset value, disables it.
// [RQ3] Source 0: main clock divided by 1,2,4,8,16,2048,4096,8192 for codes 0-7; code 0 divides by 2 here.
// [RQ4] Source 1: subsystem clock divided by two to the power of the code.
// [RQ5] Bits 2..0 hold divider code, bit 3 selects the source.
// [RQ6] Output starts or stops one selected-clock cycle after enable changes.
// [RQ7] Enabling or disabling never yields a shortened high or low pulse.
// [RQ8] Software changes source or divider only while the channel is disabled.
// [RQ9] Software clears enable before STOP when main clock is the source.
// [RQ10] Subsystem source with gating bit 0 keeps running through STOP mode.
// [RQ11] Gating bit 1 with HALT on subsystem CPU clock stops subsystem output.
// [RQ12] Reset clears both select registers to zero.
// [RQ13] Software clears port bits, picks clock while disabled, then sets enable.
// [RQ14] Software keeps chosen output frequencies at or below 16 MHz.
// [RQ15] Software waits 1.5 output cycles after disable before STOP on main source.
// [RQ16] Select registers accept full byte writes and single-bit set or clear.
// [RQ17] A disabled channel holds its output steadily low.
`timescale 1ns/100ps
`include "cbo_defs.vh"

module cbo_clock_buzzer_output #(
  parameter ADDR_W = `CBO_ADDR_W // apb address width
) (
  input wire pclk, // system clock, also the main clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [ADDR_W-1:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  input wire [3:0] pstrb, // apb byte strobes
  output reg [31:0] prdata_q, // apb read data
  output reg pready_q, // apb ready
  output reg pslverr_q, // apb error, unmapped address
  input wire sub_clk, // subsystem clock pin, asynchronous
  input wire stop_mode, // system in stop mode
  input wire halt_mode, // system in halt mode
  input wire cpu_on_sub, // cpu runs from subsystem clock
  output wire clk_out_pin0, // channel 0 output pin
  output wire clk_out_pin1 // channel 1 output pin
);

  // ---------------- decode helpers
  function [3:0] reg_decode;
    input [ADDR_W-1:0] a;
    reg [`CBO_IDX_W-1:0] idx;
    begin
      idx = a[`CBO_IDX_W+1:2];
      reg_decode = 4'h0;
      if (a[1:0] == 2'b00) begin
        case (idx)
          `CBO_IDX_SEL0: reg_decode = 4'h1;
          `CBO_IDX_SEL1: reg_decode = 4'h2;
          `CBO_IDX_PWR: reg_decode = 4'h3;
          `CBO_IDX_STAT: reg_decode = 4'h4;
          `CBO_IDX_SET0: reg_decode = 4'h5;
          `CBO_IDX_CLR0: reg_decode = 4'h6;
          `CBO_IDX_SET1: reg_decode = 4'h7;
          `CBO_IDX_CLR1: reg_decode = 4'h8;
          default: reg_decode = 4'h0;
        endcase
      end
    end
  endfunction

  localparam [3:0] R_NONE = 4'h0;
  localparam [3:0] R_SEL0 = 4'h1;
  localparam [3:0] R_SEL1 = 4'h2;
  localparam [3:0] R_PWR = 4'h3;
  localparam [3:0] R_STAT = 4'h4;
  localparam [3:0] R_SET0 = 4'h5;
  localparam [3:0] R_CLR0 = 4'h6;
  localparam [3:0] R_SET1 = 4'h7;
  localparam [3:0] R_CLR1 = 4'h8;

  // new select value from a plain, set or clear write
  function [7:0] sel_update;
    input [7:0] cur;
    input [7:0] wd;
    input [1:0] kind;
    begin
      case (kind)
        2'd1: sel_update = wd & 8'h8F; // [RQ16]
        2'd2: sel_update = cur | (wd & 8'h8F); // [RQ16]
        2'd3: sel_update = cur & ~(wd & 8'h8F); // [RQ16]
        default: sel_update = cur;
      endcase
    end
  endfunction

  // low bits that must be all ones for a tick
  function [`CBO_MAIN_CNT_W-1:0] ones_mask;
    input [3:0] n;
    begin
      ones_mask = (13'h0001 << n) - 13'h0001;
    end
  endfunction

  // main divider exponent per code
  function [3:0] main_shift;
    input [2:0] code;
    begin
      case (code)
        3'd0: main_shift = 4'd0;
        3'd1: main_shift = 4'd1;
        3'd2: main_shift = 4'd2;
        3'd3: main_shift = 4'd3;
        3'd4: main_shift = 4'd4;
        3'd5: main_shift = 4'd11;
        3'd6: main_shift = 4'd12;
        3'd7: main_shift = 4'd13;
        default: main_shift = 4'd0;
      endcase
    end
  endfunction

  // half-period exponent in pclk cycles; code 0 limited to pclk/2
  function [3:0] main_half;
    input [2:0] code;
    reg [3:0] s;
    begin
      s = main_shift(code); // [RQ3]
      main_half = (s == 4'd0) ? 4'd0 : s - 4'd1;
    end
  endfunction

  // ---------------- registers
  reg [7:0] sel0_q;
  reg [7:0] sel1_q;
  reg [7:0] pwr_q;
  reg [3:0] rsel_q;
  reg sub_lvl_q;

  wire setup_ph;
  wire acc_wr;
  wire lane0;
  wire [3:0] rsel_d;
  wire [1:0] kind0;
  wire [1:0] kind1;
  wire out0;
  wire out1;
  wire act0;
  wire act1;
  reg [7:0] rdata_d;

  assign setup_ph = psel & ~penable;
  assign rsel_d = reg_decode(paddr);
  // write lands at the access edge where ready is seen high
  assign acc_wr = psel & penable & pwrite & pready_q;
  assign lane0 = pstrb[0];

  assign kind0 = (!acc_wr || !lane0) ? 2'd0 :
                 (rsel_q == R_SEL0) ? 2'd1 :
                 (rsel_q == R_SET0) ? 2'd2 :
                 (rsel_q == R_CLR0) ? 2'd3 : 2'd0;
  assign kind1 = (!acc_wr || !lane0) ? 2'd0 :
                 (rsel_q == R_SEL1) ? 2'd1 :
                 (rsel_q == R_SET1) ? 2'd2 :
                 (rsel_q == R_CLR1) ? 2'd3 : 2'd0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel0_q <= `CBO_SEL_RESET; // [RQ12]
      sel1_q <= `CBO_SEL_RESET; // [RQ12]
      pwr_q <= `CBO_PWR_RESET;
    end else begin
      sel0_q <= sel_update(sel0_q, pwdata[7:0], kind0); // [RQ1]
      sel1_q <= sel_update(sel1_q, pwdata[7:0], kind1); // [RQ1]
      if (acc_wr && lane0 && rsel_q == R_PWR) begin
        pwr_q <= {7'h00, pwdata[`CBO_PWR_LPGATE_BIT]};
      end
    end
  end

  // ---------------- read mux
  always @* begin
    case (rsel_d)
      R_SEL0: rdata_d = sel0_q;
      R_SEL1: rdata_d = sel1_q;
      R_SET0: rdata_d = sel0_q;
      R_CLR0: rdata_d = sel0_q;
      R_SET1: rdata_d = sel1_q;
      R_CLR1: rdata_d = sel1_q;
      R_PWR: rdata_d = pwr_q;
      R_STAT: rdata_d = {3'h0, sub_lvl_q, act1, out1, act0, out0};
      default: rdata_d = 8'h00;
    endcase
  end

  // ---------------- apb answer: one access cycle, no waits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      rsel_q <= R_NONE;
    end else begin
      pready_q <= setup_ph;
      if (setup_ph) begin
        rsel_q <= rsel_d;
        pslverr_q <= (rsel_d == R_NONE);
        prdata_q <= pwrite ? 32'h00000000 : {24'h000000, rdata_d};
      end else if (pready_q) begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h00000000;
        rsel_q <= R_NONE;
      end
    end
  end

  // ---------------- subsystem clock pin: three-stage synchroniser
  reg sub_s1_q;
  reg sub_s2_q;
  reg sub_s3_q;
  wire sub_edge;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
      sub_lvl_q <= 1'b0;
    end else begin
      sub_s1_q <= sub_clk;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
      if (sub_s2_q == sub_s3_q) begin
        sub_lvl_q <= sub_s3_q;
      end
    end
  end

  assign sub_edge = (sub_s2_q == sub_s3_q) && (sub_s3_q != sub_lvl_q);

  // ---------------- shared prescalers
  reg [`CBO_MAIN_CNT_W-1:0] mcnt_q;
  reg [`CBO_SUB_CNT_W-1:0] scnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcnt_q <= {`CBO_MAIN_CNT_W{1'b0}};
      scnt_q <= {`CBO_SUB_CNT_W{1'b0}};
    end else begin
      mcnt_q <= mcnt_q + 13'h0001;
      if (sub_edge) begin
        scnt_q <= scnt_q + 7'h01;
      end
    end
  end

  // ---------------- clock availability
  wire main_run;
  wire sub_run;

  // main clock halts in stop mode
  assign main_run = ~stop_mode; // [RQ9]
  assign sub_run = ~(pwr_q[`CBO_PWR_LPGATE_BIT] & halt_mode & cpu_on_sub); // [RQ10] [RQ11]

  // half-period event for a select value
  function chan_tick;
    input [7:0] sel;
    input [`CBO_MAIN_CNT_W-1:0] mc;
    input [`CBO_SUB_CNT_W-1:0] sc;
    input se;
    input mrun;
    input srun;
    reg [`CBO_MAIN_CNT_W-1:0] mm;
    reg [`CBO_MAIN_CNT_W-1:0] sm;
    begin
      mm = ones_mask(main_half(sel[`CBO_DIV_MSB:`CBO_DIV_LSB]));
      sm = ones_mask({1'b0, sel[`CBO_DIV_MSB:`CBO_DIV_LSB]});
      if (sel[`CBO_SRC_BIT]) begin
        chan_tick = srun & se & (({6'h00, sc} & sm) == sm); // [RQ4] [RQ5]
      end else begin
        chan_tick = mrun & ((mc & mm) == mm); // [RQ3] [RQ5]
      end
    end
  endfunction

  wire tick0;
  wire tick1;

  assign tick0 = chan_tick(sel0_q, mcnt_q, scnt_q, sub_edge, main_run, sub_run);
  assign tick1 = chan_tick(sel1_q, mcnt_q, scnt_q, sub_edge, main_run, sub_run);

  // ---------------- channels
  cbo_chan u_chan0 (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick0),
    .en(sel0_q[`CBO_EN_BIT]), // [RQ2]
    .out_q(out0),
    .active_q(act0)
  );

  cbo_chan u_chan1 (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick1),
    .en(sel1_q[`CBO_EN_BIT]), // [RQ2]
    .out_q(out1),
    .active_q(act1)
  );

  assign clk_out_pin0 = out0; // [RQ1]
  assign clk_out_pin1 = out1; // [RQ1]

endmodule // cbo_clock_buzzer_output

// ---- cbo_listener.sv ----
`timescale 1ns/100ps
// peripheral clock input: measures phase lengths of the received clock
module cbo_listener (
  input wire pclk, // sampling clock
  input wire pin, // received clock
  output reg [15:0] hi_q, // length of last high phase
  output reg [15:0] lo_q, // length of last low phase
  output reg [15:0] rises_q // rising edges seen
);
  reg [15:0] run_q;
  reg last_q;
  initial begin
    run_q = 0;
    last_q = 0;
    hi_q = 0;
    lo_q = 0;
    rises_q = 0;
  end
  always @(posedge pclk) begin
    last_q <= pin;
    run_q <= (pin != last_q) ? 16'h0001 : run_q + 16'h0001;
    if (pin && !last_q) begin
      lo_q <= run_q;
      rises_q <= rises_q + 16'h0001;
    end
    if (!pin && last_q) hi_q <= run_q;
  end
endmodule // cbo_listener

// ---- cbo_props_properties.sv ----
`timescale 1ns/100ps
`include "cbo_defs.vh"
module cbo_props #(parameter ADDR_W = 22) (
  input wire pclk, // clock
  input wire presetn, // reset
  input wire psel, // select
  input wire penable, // enable
  input wire pwrite, // direction
  input wire [ADDR_W-1:0] paddr, // address
  input wire [31:0] pwdata, // write data
  input wire [3:0] pstrb, // strobes
  input wire [31:0] prdata_q, // read data
  input wire pready_q, // ready
  input wire pslverr_q, // error
  input wire stop_mode, // stop
  input wire clk_out_pin0, // pin 0
  input wire clk_out_pin1 // pin 1
);
  localparam [ADDR_W-1:0] A0 = {`CBO_IDX_SEL0, 2'b00};
  localparam [ADDR_W-1:0] A1 = {`CBO_IDX_SEL1, 2'b00};
  wire wr = psel && penable && pready_q && pwrite && pstrb[0];
  reg [7:0] s0_q, s1_q;
  reg [1:0] d0_q;
  // shadow of the select registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s0_q <= 8'h00;
      s1_q <= 8'h00;
      d0_q <= 2'h0;
    end else begin
      if (wr && paddr == A0) s0_q <= pwdata[7:0] & `CBO_SEL_WMASK;
      if (wr && paddr == A1) s1_q <= pwdata[7:0] & `CBO_SEL_WMASK;
      d0_q <= {d0_q[0], s0_q[7]};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready_q; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_err; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr_q; endproperty
  a_err: assert property (p_err) else $error("misaligned access not refused");
  property p_hi; pready_q |-> prdata_q[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_rb0; pready_q && !pwrite && paddr == A0 |-> prdata_q[7:0] == s0_q; endproperty
  a_rb0: assert property (p_rb0) else $error("select 0 readback wrong");
  property p_rb1; pready_q && !pwrite && paddr == A1 |-> prdata_q[7:0] == s1_q; endproperty
  a_rb1: assert property (p_rb1) else $error("select 1 readback wrong");
  property p_rst; $rose(presetn) |-> !clk_out_pin0 && !clk_out_pin1; endproperty
  a_rst: assert property (p_rst) else $error("pin high after reset");
  property p_off; d0_q == 2'h0 && !s0_q[7] && !clk_out_pin0 |=> !clk_out_pin0; endproperty
  a_off: assert property (p_off) else $error("disabled pin rose");
  property p_stop; stop_mode && $past(stop_mode) && !s0_q[3] |=> $stable(clk_out_pin0); endproperty
  a_stop: assert property (p_stop) else $error("main output moved in stop");
  property p_div2;
    s0_q == 8'h81 && $past(s0_q, 4) == 8'h81 && !stop_mode && !$past(stop_mode)
      |=> clk_out_pin0 != $past(clk_out_pin0);
  endproperty
  a_div2: assert property (p_div2) else $error("main half rate not toggling");
endmodule // cbo_props
bind cbo_clock_buzzer_output cbo_props #(.ADDR_W(ADDR_W)) cbo_props_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .stop_mode(stop_mode),
  .clk_out_pin0(clk_out_pin0), .clk_out_pin1(clk_out_pin1));

// ---- cbo_clock_buzzer_output_bench.sv ----
`timescale 1ns/100ps
`include "cbo_defs.vh"
module cbo_clock_buzzer_output_bench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sub_clk = 0;
  reg stop_mode = 0, halt_mode = 0, cpu_on_sub = 0;
  reg [21:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg [3:0] pstrb = 0;
  wire [31:0] prdata_q;
  wire pready_q, pslverr_q, clk_out_pin0, clk_out_pin1;
  wire [15:0] hi, lo, rises;
  integer failures = 0, checks = 0, c, h, r0;
  reg [31:0] rd;
  reg er;
  localparam [21:0] A0 = {`CBO_IDX_SEL0, 2'b00};
  localparam [21:0] A1 = {`CBO_IDX_SEL1, 2'b00};
  localparam [21:0] AP = {`CBO_IDX_PWR, 2'b00};
  always #4 pclk = ~pclk;
  initial begin
    #1;
    forever #96 sub_clk = ~sub_clk;
  end
  cbo_clock_buzzer_output cbo_clock_buzzer_output_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .sub_clk(sub_clk), .stop_mode(stop_mode),
    .halt_mode(halt_mode), .cpu_on_sub(cpu_on_sub), .clk_out_pin0(clk_out_pin0), .clk_out_pin1(clk_out_pin1));
  cbo_listener cbo_listener_inst (.pclk(pclk), .pin(clk_out_pin0), .hi_q(hi), .lo_q(lo), .rises_q(rises));
  task print_verdict;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one apb transfer, released after ready is sampled or after 20 access cycles without it
  task apb(input w, input [21:0] a, input [7:0] d, input [3:0] s);
    integer n;
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready_q !== 1'b1 && n < 20);
      if (n >= 20) failures = failures + 1;
      rd = prdata_q;
      er = pslverr_q;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task rd8(input [21:0] a, input [7:0] e);
    begin
      apb(0, a, 8'h00, 4'hF);
      chk(rd, {24'h0, e}, "read");
    end
  endtask
  task wait_rises(input integer n);
    integer k;
    begin
      r0 = rises;
      k = 0;
      while (rises < r0 + n && k < 40000) begin
        @(posedge pclk);
        k = k + 1;
      end
    end
  endtask
  task t_regs;
    begin
      rd8(A0, 8'h00);
      rd8(A1, 8'h00);
      chk(clk_out_pin0, 0, "pin0 idle");
      apb(1, A0, 8'h7F, 4'h0);
      rd8(A0, 8'h00);
      apb(1, A0, 8'h7F, 4'hF);
      rd8(A0, 8'h0F);
      apb(1, A1, 8'h03, 4'hF);
      rd8(A1, 8'h03);
      apb(0, A0 + 22'h1, 8'h00, 4'hF);
      chk(er, 1, "misaligned error");
      apb(1, A1, 8'h00, 4'hF);
    end
  endtask
  task t_main;
    for (c = 0; c < 8; c = c + 1) begin
      h = (c == 0) ? 1 : (c < 5) ? (1 << (c - 1)) : (1 << (c + 5));
      apb(1, A0, c, 4'hF);
      apb(1, A0, 8'h80 | c, 4'hF);
      wait_rises(2);
      chk(hi, h, "first high");
      chk(lo, h, "low phase");
      chk(clk_out_pin1, 0, "pin1 quiet");
      apb(1, A0, c, 4'hF);
      repeat (h + 3) @(posedge pclk);
      r0 = rises;
      repeat (2 * h) @(posedge pclk);
      chk(rises, r0, "stopped");
      chk(clk_out_pin0, 0, "low when off");
    end
  endtask
  task t_sub;
    begin
      for (c = 2; c >= 0; c = c - 2) begin
        apb(1, A0, 8'h08 | c, 4'hF);
        apb(1, A0, 8'h88 | c, 4'hF);
        wait_rises(2);
        chk(hi, 12 << c, "sub high");
        chk(lo, 12 << c, "sub low");
        if (c > 0) begin
          apb(1, A0, 8'h08 | c, 4'hF);
          repeat (200) @(posedge pclk);
        end
      end
      stop_mode <= 1;
      wait_rises(2);
      chk(rises - r0, 2, "runs in stop");
      apb(1, AP, 8'h01, 4'hF);
      stop_mode <= 0;
      halt_mode <= 1;
      cpu_on_sub <= 1;
      repeat (30) @(posedge pclk);
      r0 = rises;
      repeat (60) @(posedge pclk);
      chk(rises, r0, "gated in halt");
      halt_mode <= 0;
      apb(1, AP, 8'h00, 4'hF);
      apb(1, A0, 8'h08, 4'hF);
      repeat (200) @(posedge pclk);
      apb(1, A0, 8'h02, 4'hF);
      apb(1, A0, 8'h82, 4'hF);
      repeat (20) @(posedge pclk);
      apb(1, A0, 8'h02, 4'hF);
      repeat (8) @(posedge pclk);
      stop_mode <= 1;
      repeat (10) @(posedge pclk);
      chk(clk_out_pin0, 0, "low in stop");
      stop_mode <= 0;
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    t_main;
    t_sub;
    print_verdict;
  end
  initial begin
    repeat (95000) @(posedge pclk);
    failures = failures + 1;
    print_verdict;
  end
endmodule // cbo_clock_buzzer_output_bench
